// *** logic/gps_cfg.svh ***
// Constants of the gauge pack status and configuration bank
//
// Contract
// - Seal bit reads 1 sealed, 0 unsealed
// - Discharge-qualified bit follows cycle qualification
// - Safety bit latches until reset only
// - Over-limit bit follows present fault, unlatched
// - Under-limit bit follows present fault, unlatched
// - Cell commands return cell millivolts
// - Flash read at reset, written for history
// - Status word: status low, pack config high
// - Fixed status bit positions, bit 3 zero
`ifndef GPS_CFG_SVH
`define GPS_CFG_SVH

// ==========================================================
// Command codes
`define GPS_CMD_PACK_STATUS 8'h2f
`define GPS_CMD_CELL4 8'h3c
`define GPS_CMD_CELL3 8'h3d
`define GPS_CMD_CELL2 8'h3e
`define GPS_CMD_CELL1 8'h3f

// ==========================================================
// Status byte layout
`define GPS_BIT_AFE 7
`define GPS_BIT_EDV 6
`define GPS_BIT_SEAL 5
`define GPS_BIT_DSG_QUAL 4
`define GPS_BIT_ZERO 3
`define GPS_BIT_SAFETY 2
`define GPS_BIT_OVERLIMIT 1
`define GPS_BIT_UNDERLIMIT 0
`define GPS_STATUS_RESET 8'h00

// ==========================================================
// Configuration flash
`define GPS_FLASH_AW 8
`define GPS_FLASH_DEPTH 256
`define GPS_FLASH_PACK_CFG 8'h28
`define GPS_PACK_CFG_RESET 8'h00

`endif

// *** logic/gps_pkg.sv ***
// Types shared by the gauge pack status and configuration bank
package gps_pkg;

    // ==========================================================
    // Controller states, one-hot
    typedef enum logic [2:0]
    {
        GPS_ST_LOAD = 3'b001,
        GPS_ST_RUN = 3'b010,
        GPS_ST_IDLE = 3'b100
    } gps_state_type;

    // ==========================================================
    // Carriers
    typedef struct packed
    {
        logic [15:0] cell4;
        logic [15:0] cell3;
        logic [15:0] cell2;
        logic [15:0] cell1;
    } gps_cells_type;

    typedef struct packed
    {
        logic afe_fail;
        logic edv_low;
        logic sealed;
        logic dsg_qualified;
        logic safety_exceeded;
        logic overlimit_fault;
        logic underlimit_fault;
    } gps_faults_type;

    typedef struct packed
    {
        logic valid;
        logic write;
        logic [7:0] code;
    } gps_cmd_type;

    typedef struct packed
    {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } gps_flash_wr_type;

endpackage

// *** logic/gps_flash_mem.sv ***
// Configuration flash array with registered read data
`timescale 1ns/100ps
`include "gps_cfg.svh"
module gps_flash_mem
    import gps_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [`GPS_FLASH_AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:`GPS_FLASH_DEPTH-1];

    // ==========================================================
    // Array write
    always_ff @(posedge i_mclk)
    begin
        if (i_we)
        begin
            mem[i_addr] <= i_wdata;
        end
    end

    // ==========================================================
    // Read port; holds last word when idle
    always_ff @(posedge i_mclk)
    begin
        if (i_re)
        begin
            o_rdata <= mem[i_addr];
        end
    end
endmodule

// *** logic/gps_status_bank.sv ***
// Pack status flags, cell readback words and configuration flash control
`timescale 1ns/100ps
`include "gps_cfg.svh"
module gps_status_bank
    import gps_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire gps_faults_type i_faults,
    input wire logic i_cell_update,
    input wire gps_cells_type i_cell_mv,
    input wire gps_cmd_type i_cmd,
    input wire gps_flash_wr_type i_hist_wr,
    input wire gps_flash_wr_type i_prog_wr,
    output logic o_rsp_valid,
    output logic o_rsp_ack,
    output logic [15:0] o_rsp_data,
    output logic [7:0] o_pack_state_flags,
    output logic [7:0] o_pack_cfg,
    output logic o_init_done
);
    gps_state_type state;
    gps_state_type next_state;
    gps_cells_type cells;
    logic [7:0] next_flags;
    logic [7:0] flash_rdata;
    logic flash_we;
    logic flash_re;
    logic [`GPS_FLASH_AW-1:0] flash_addr;
    logic [7:0] flash_wdata;
    logic hist_ok;

    // ==========================================================
    // Command decode helpers
    function automatic logic is_cell_cmd(input logic [7:0] code);
        return (code >= `GPS_CMD_CELL4) && (code <= `GPS_CMD_CELL1);
    endfunction

    function automatic logic [15:0] cell_of(input logic [7:0] code, input gps_cells_type c);
        logic [15:0] v;
        v = 16'h0000;
        unique case (code)
            `GPS_CMD_CELL4: v = c.cell4;
            `GPS_CMD_CELL3: v = c.cell3;
            `GPS_CMD_CELL2: v = c.cell2;
            `GPS_CMD_CELL1: v = c.cell1;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Load sequencer
    always_comb
    begin
        next_state = state;
        unique case (state)
            GPS_ST_LOAD: next_state = GPS_ST_RUN;
            GPS_ST_RUN: next_state = GPS_ST_RUN;
            GPS_ST_IDLE: next_state = GPS_ST_RUN;
            default: next_state = GPS_ST_LOAD;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            state <= GPS_ST_LOAD;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Flash port
    // access limited to reset load, history stores and programmer writes
    // A history store raised on the edge that asserts reset is dropped; programmer writes still land during reset
    assign hist_ok = i_hist_wr.we && (state == GPS_ST_RUN) && !i_reset;
    assign flash_re = (state == GPS_ST_LOAD);
    // The external programmer owns the array; its write wins a collision
    assign flash_we = i_prog_wr.we || hist_ok;
    assign flash_addr = i_prog_wr.we ? i_prog_wr.addr
                      : (flash_re ? `GPS_FLASH_PACK_CFG : i_hist_wr.addr);
    assign flash_wdata = i_prog_wr.we ? i_prog_wr.data : i_hist_wr.data;

    gps_flash_mem u_flash
    (
        .i_mclk(i_mclk),
        .i_we(flash_we),
        .i_re(flash_re),
        .i_addr(flash_addr),
        .i_wdata(flash_wdata),
        .o_rdata(flash_rdata)
    );

    // ==========================================================
    // Pack configuration, taken once per reset
    // high byte copied from flash at load
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_pack_cfg <= `GPS_PACK_CFG_RESET;
            o_init_done <= 1'b0;
        end
        else if (state == GPS_ST_LOAD)
        begin
            o_pack_cfg <= flash_rdata;
            o_init_done <= 1'b1;
        end
    end

    // ==========================================================
    // Status flags
    always_comb
    begin
        next_flags = `GPS_STATUS_RESET;
        next_flags[`GPS_BIT_AFE] = i_faults.afe_fail;
        next_flags[`GPS_BIT_EDV] = i_faults.edv_low;
        next_flags[`GPS_BIT_SEAL] = i_faults.sealed;
        next_flags[`GPS_BIT_DSG_QUAL] = i_faults.dsg_qualified;
        next_flags[`GPS_BIT_ZERO] = 1'b0;
        // sticky safety latch, only reset clears
        next_flags[`GPS_BIT_SAFETY] = o_pack_state_flags[`GPS_BIT_SAFETY]
                                    || i_faults.safety_exceeded;
        next_flags[`GPS_BIT_OVERLIMIT] = i_faults.overlimit_fault;
        next_flags[`GPS_BIT_UNDERLIMIT] = i_faults.underlimit_fault;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_pack_state_flags <= `GPS_STATUS_RESET;
        end
        else
        begin
            o_pack_state_flags <= next_flags;
        end
    end

    // ==========================================================
    // Cell voltage words
    // only the measurement strobe and reset change them
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            cells <= '0;
        end
        else if (i_cell_update)
        begin
            cells <= i_cell_mv;
        end
    end

    // ==========================================================
    // Command answers
    // Writes and unknown codes are answered without ack and change nothing
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_rsp_valid <= 1'b0;
            o_rsp_ack <= 1'b0;
            o_rsp_data <= 16'h0000;
        end
        else
        begin
            o_rsp_valid <= i_cmd.valid;
            o_rsp_ack <= 1'b0;
            o_rsp_data <= 16'h0000;
            if (i_cmd.valid && !i_cmd.write && state == GPS_ST_RUN)
            begin
                // status low byte, config high byte
                if (i_cmd.code == `GPS_CMD_PACK_STATUS)
                begin
                    o_rsp_ack <= 1'b1;
                    o_rsp_data <= {o_pack_cfg, o_pack_state_flags};
                end
                else if (is_cell_cmd(i_cmd.code))
                begin
                    o_rsp_ack <= 1'b1;
                    o_rsp_data <= cell_of(i_cmd.code, cells);
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    seal_flag_a: assert property (
        ##1 o_pack_state_flags[`GPS_BIT_SEAL] == $past(i_faults.sealed))
        else $error("seal flag does not follow seal state");

    dsg_qual_a: assert property (
        !i_faults.dsg_qualified |=> !o_pack_state_flags[`GPS_BIT_DSG_QUAL])
        else $error("discharge-qualified flag set while not qualified");

    safety_sticky_a: assert property (
        i_faults.safety_exceeded |=> o_pack_state_flags[`GPS_BIT_SAFETY] [*2])
        else $error("safety flag not set or not held");

    safety_hold_a: assert property (
        o_pack_state_flags[`GPS_BIT_SAFETY] |=> o_pack_state_flags[`GPS_BIT_SAFETY])
        else $error("safety flag cleared without reset");

    overlimit_live_a: assert property (
        ##1 o_pack_state_flags[`GPS_BIT_OVERLIMIT] == $past(i_faults.overlimit_fault))
        else $error("over-limit flag does not follow fault");

    underlimit_live_a: assert property (
        !i_faults.underlimit_fault |=> !o_pack_state_flags[`GPS_BIT_UNDERLIMIT])
        else $error("under-limit flag set without fault");

    cell_answer_a: assert property (
        i_cmd.valid && !i_cmd.write && i_cmd.code == `GPS_CMD_CELL4 && o_init_done
        |=> o_rsp_ack && o_rsp_data == $past(cells.cell4))
        else $error("cell 4 command answered with wrong word");

    flash_access_a: assert property (
        flash_we |-> i_prog_wr.we || (i_hist_wr.we && o_init_done))
        else $error("flash written outside history store");

    status_word_a: assert property (
        i_cmd.valid && !i_cmd.write && i_cmd.code == `GPS_CMD_PACK_STATUS && o_init_done
        |=> o_rsp_data == {o_pack_cfg, $past(o_pack_state_flags)})
        else $error("status word layout wrong");

    zero_bit_a: assert property (
        ##1 !o_pack_state_flags[`GPS_BIT_ZERO])
        else $error("status bit 3 not zero");

    read_only_a: assert property (
        !i_cell_update |=> $stable(cells))
        else $error("cell word changed without measurement");

    write_refused_a: assert property (
        i_cmd.valid && i_cmd.write |=> o_rsp_valid && !o_rsp_ack)
        else $error("write command acknowledged");

    status_read_c: cover property (
        o_rsp_valid && o_rsp_ack && o_rsp_data[`GPS_BIT_SAFETY]);
    cell_read_c: cover property (
        i_cmd.valid && is_cell_cmd(i_cmd.code) ##1 o_rsp_ack);
    hist_store_c: cover property (hist_ok);
endmodule

// *** testbench/gps_host_model.sv ***
// Host model issuing word commands to the status bank
`timescale 1ns/100ps
module gps_host_model
    import gps_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rsp_valid,
    input wire logic i_rsp_ack,
    input wire logic [15:0] i_rsp_data,
    output gps_cmd_type o_cmd
);
    initial o_cmd = '0;

    // ==========================================================
    // Word transfer: request held over one edge, answer taken while it stands
    task automatic xfer(input logic wr, input logic [7:0] code, output logic [17:0] rsp);
        o_cmd = {1'b1, wr, code};
        @(posedge i_mclk);
        #1;
        // Answer stands only for the cycle after the taking edge
        rsp = {i_rsp_valid, i_rsp_ack, i_rsp_data};
        // Released lines show the inverse so a stale capture is caught
        o_cmd = {1'b0, ~wr, ~code};
        @(posedge i_mclk);
        #1;
    endtask
endmodule

// *** testbench/gauge_pack_status_and_config_tb_top.sv ***
// Self-checking bench of the pack status and configuration bank
`timescale 1ns/100ps
`include "gps_cfg.svh"
module gauge_pack_status_and_config_tb_top import gps_pkg::*;;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    gps_faults_type faults = '0;
    logic cell_update = 1'b0;
    gps_cells_type cell_mv = '0;
    gps_cells_type cells;
    gps_cmd_type cmd;
    gps_flash_wr_type hist_wr = '0;
    gps_flash_wr_type prog_wr = '0;
    logic rsp_valid;
    logic rsp_ack;
    logic [15:0] rsp_data;
    logic [7:0] flags;
    logic [7:0] pack_cfg;
    logic init_done;
    logic [17:0] rsp;
    int err_total = 0;
    int cmp_count = 0;

    gps_status_bank u_dut (
        .i_mclk(mclk),
        .i_reset(reset),
        .i_faults(faults),
        .i_cell_update(cell_update),
        .i_cell_mv(cell_mv),
        .i_cmd(cmd),
        .i_hist_wr(hist_wr),
        .i_prog_wr(prog_wr),
        .o_rsp_valid(rsp_valid),
        .o_rsp_ack(rsp_ack),
        .o_rsp_data(rsp_data),
        .o_pack_state_flags(flags),
        .o_pack_cfg(pack_cfg),
        .o_init_done(init_done)
    );

    gps_host_model u_host (
        .i_mclk(mclk),
        .i_rsp_valid(rsp_valid),
        .i_rsp_ack(rsp_ack),
        .i_rsp_data(rsp_data),
        .o_cmd(cmd)
    );

    always #12.5 mclk = ~mclk;

    // ==========================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rsp(input logic wr, input logic [7:0] code, input logic [16:0] exp);
        u_host.xfer(wr, code, rsp);
        cmp_count++;
        if (rsp !== {1'b1, exp})
        begin
            err_total++;
            $display("mismatch at %0t: code %h answer %h", $time, code, rsp);
        end
    endtask

    function automatic logic [7:0] exp_flags(input gps_faults_type f, input logic latch);
        return {f.afe_fail, f.edv_low, f.sealed, f.dsg_qualified, 1'b0, latch,
            f.overlimit_fault, f.underlimit_fault};
    endfunction

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Watchdog, far beyond the expected run of about a hundred cycles
    initial
    begin
        #25000;
        err_total++;
        print_verdict();
    end

    // ==========================================================
    // Tests
    initial
    begin
        tick(2);
        // pack configuration loaded before the gauge is relied on
        prog_wr = {1'b1, 8'h28, 8'hc2};
        tick(1);
        prog_wr = '0;
        tick(17);
        reset = 1'b0;
        tick(1);
        chk_word({7'h0, init_done, pack_cfg}, {8'h01, 8'hc2}); // load at reset
        chk_rsp(1'b0, `GPS_CMD_PACK_STATUS, {1'b1, 8'hc2, 8'h00}); // status word
        for (int i = 0; i < 7; i++)
        begin
            if (i != 2)
            begin
                faults = 7'(1 << i);
                tick(2);
                chk_word({8'h00, flags}, {8'h00, exp_flags(faults, 1'b0)});
                chk_rsp(1'b0, `GPS_CMD_PACK_STATUS, {1'b1, 8'hc2, exp_flags(faults, 1'b0)});
                faults = '0;
                tick(2);
                chk_word({8'h00, flags}, 16'h0000); // unlatched
            end
        end
        faults.safety_exceeded = 1'b1;
        tick(1);
        faults = '0;
        tick(3);
        chk_word({8'h00, flags}, 16'h0004); // latch holds
        chk_rsp(1'b0, `GPS_CMD_PACK_STATUS, {1'b1, 8'hc2, 8'h04}); // latch in word
        chk_rsp(1'b1, `GPS_CMD_PACK_STATUS, 17'h0_0000); // write refused
        chk_rsp(1'b0, 8'h30, 17'h0_0000); // unknown code refused
        chk_word({8'h00, flags}, 16'h0004); // flags untouched
        cells = {16'h1004, 16'h0ffc, 16'h0e10, 16'h0b48};
        cell_mv = cells;
        cell_update = 1'b1;
        tick(1);
        cell_update = 1'b0;
        // Changed inputs must not leak in without a load pulse
        cell_mv = ~cells;
        for (int c = 0; c < 4; c++)
        begin
            chk_rsp(1'b0, `GPS_CMD_CELL4 + 8'(c), {1'b1, cells[63-16*c -: 16]});
        end
        chk_rsp(1'b1, `GPS_CMD_CELL1, 17'h0_0000); // write refused
        chk_rsp(1'b0, `GPS_CMD_CELL1, {1'b1, cells[15:0]}); // value kept
        hist_wr = {1'b1, 8'h28, 8'h5a};
        tick(1);
        // History write on the edge that raises reset must be ignored
        hist_wr = {1'b1, 8'h28, 8'h33};
        reset = 1'b1;
        tick(1);
        hist_wr = '0;
        tick(2);
        reset = 1'b0;
        tick(1);
        chk_word({7'h0, init_done, pack_cfg}, {8'h01, 8'h5a}); // history store
        chk_word({8'h00, flags}, 16'h0000); // reset clears latch
        print_verdict();
    end
endmodule
